// ==== core/async_rs232_port_adapter.sv ====
`timescale 1ns/100ps
module async_rs232_port_adapter
    import port_adapter_pkg::*;
#(
    parameter int UNIT = 0,
    parameter int BREAK_REL = BREAK_REL_CYC,
    parameter int BREAK_FWD = BREAK_FWD_CYC,
    parameter int DTR_DROP = DTR_DROP_CYC,
    parameter int LAMP = LAMP_CYC,
    parameter int BLINK_HALF = BLINK_HALF_CYC
) (
    input wire logic clock, // 20 MHz
    input wire logic rst, // Synchronous, high
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address taken
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Byte lanes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data taken
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response taken
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address taken
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data taken
    input wire lead_t leadIn, // Lead levels seen at pins
    output lead_t leadOut, // Lead drive levels
    output lead_t leadOe, // Lead drive enables
    input wire logic [7:0] netRxData, // Character toward equipment
    input wire logic netRxValid, // Character offered
    output logic netRxReady, // Transmitter free
    output logic [7:0] netTxData, // Character from equipment
    output logic netTxValid, // One-cycle strobe
    input wire logic callIn, // Incoming call pulse
    input wire logic reloadIn, // Far-end reload pulse
    input wire call_par_t callParams, // Parameters with either pulse
    output logic callAccept, // Call taken pulse
    output logic callReject, // Parameters refused pulse
    output logic callDrop, // Call released pulse
    output logic callActive, // Call up
    input wire logic selfTestFail, // Self-test verdict
    input wire logic selButton, // Port-select button pin
    output logic [5:0] indicator // Faceplate indicators
);

if (UNIT < 0 || UNIT > 2 || BREAK_FWD >= BREAK_REL || BREAK_REL >= 2 ** TIMER_W
        || DTR_DROP < 1 || LAMP < 1 || BLINK_HALF < 1 || BREAK_FWD < 1) begin
    $error("port adapter parameters out of range");
end

localparam logic [5:0] PAIR = 6'(6'h30 >> (2 * UNIT));

lead_t leadS1_reg, leadS2_reg;
logic btnS1_reg, btnS2_reg, btnPrev_reg;
logic [7:0] ctrl_reg, cfg_reg;
logic hangup_reg;
logic sevenPar_reg, oddPar_reg;
logic [3:0] rateIdx_reg, abIdx_reg;
logic abArmed_reg, abMeas_reg, abDone_reg;
logic [19:0] abCnt_reg;
rx_t rxSt_reg;
logic [19:0] rxCnt_reg, txCnt_reg;
logic [2:0] rxBit_reg;
logic [7:0] rxShift_reg;
par_t par_reg;
logic [10:0] txFrame_reg;
logic [3:0] txLeft_reg;
logic txLine_reg;
logic [TIMER_W-1:0] brkCnt_reg, dtrCnt_reg, dgCnt_reg;
diag_t dg_reg;
logic blink_reg;
logic [31:0] statWord;
logic cfgDce, cfgKbd, autoSel, rxLine, rxHold, callOk, brkHit, dropCall, adopt, btnRise;
logic [3:0] cfgRate;
logic [19:0] div;
par_t txPar;

// Slowest rate whose three-quarter bit time the measured start bit reaches
function automatic logic [3:0] pickRate(input logic [19:0] w);
    logic [21:0] lim;
    pickRate = RATE_NONE;
    for (int i = 8; i >= 0; i--) begin
        lim = (22'(bitDiv(4'(i))) * 22'h3) >> 2;
        if ({2'h0, w} >= lim) begin
            pickRate = 4'(i);
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////////

always_ff @(posedge clock) begin
    if (rst) begin
        leadS1_reg <= LEAD_IDLE;
        leadS2_reg <= LEAD_IDLE;
        btnS1_reg <= 1'b0;
        btnS2_reg <= 1'b0;
        btnPrev_reg <= 1'b0;
    end else begin
        leadS1_reg <= leadIn;
        leadS2_reg <= leadS1_reg;
        btnS1_reg <= selButton;
        btnS2_reg <= btnS1_reg;
        btnPrev_reg <= btnS2_reg;
    end
end

assign cfgDce = cfg_reg[CTRL_DCE];
assign cfgKbd = cfg_reg[CTRL_KBD];
assign cfgRate = cfg_reg[CTRL_RATE_LSB +: 4];
assign autoSel = cfgRate >= NUM_RATES;
assign div = bitDiv(rateIdx_reg);
assign btnRise = btnS2_reg && !btnPrev_reg;
assign rxLine = cfgDce ? leadS2_reg.td : leadS2_reg.rd;
assign rxHold = abArmed_reg && autoSel && !callActive;
assign callOk = !(callParams.sync || callParams.halfDup || callParams.eightPar)
    && callParams.rate < NUM_RATES;
assign brkHit = !rxLine && brkCnt_reg == TIMER_W'(BREAK_REL - 1);
// open DSR or DCD drops in DTE mode only; no control lead, DTR included, consulted in DCE mode
assign dropCall = callActive
    && (brkHit || hangup_reg || (!cfgDce && (!leadS2_reg.dsr || !leadS2_reg.dcd)));
assign adopt = callOk && !dropCall && (callIn ? !callActive : reloadIn && callActive);
// transparent in call; regenerate; dialing parity
assign txPar = callActive ? (sevenPar_reg ? (oddPar_reg ? PAR_ODD : PAR_EVEN) : PAR_NONE)
    : par_reg;

always_comb begin
    statWord = '0;
    statWord[STAT_CALL] = callActive;
    statWord[STAT_BRK] = brkCnt_reg >= TIMER_W'(BREAK_FWD);
    statWord[STAT_PAR_LSB +: 3] = par_reg;
    statWord[STAT_RATE_LSB +: 4] = rateIdx_reg;
    statWord[STAT_DIAG_LSB +: 2] = dg_reg;
    statWord[STAT_AUTO] = rxHold;
end

////////////////////////////////////////////////////////////////////////////////

// Address and data are taken together, so order never matters
always_ff @(posedge clock) begin
    if (rst) begin
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= RESP_OKAY;
        ctrl_reg <= CTRL_RST;
        hangup_reg <= 1'b0;
    end else begin
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        hangup_reg <= 1'b0;
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
        if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (s_axi_awaddr == CTRL_OFS || s_axi_awaddr == STAT_OFS)
                ? RESP_OKAY : RESP_SLVERR;
            if (s_axi_awaddr == CTRL_OFS && s_axi_wstrb[0]) begin
                ctrl_reg <= s_axi_wdata[7:0] & CTRL_MASK;
                hangup_reg <= s_axi_wdata[CTRL_HANGUP];
            end
        end
    end
end

always_ff @(posedge clock) begin
    if (rst) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= RESP_OKAY;
    end else begin
        s_axi_arready <= 1'b0;
        if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
        if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (s_axi_araddr)
                CTRL_OFS: s_axi_rdata <= {24'h0, ctrl_reg};
                STAT_OFS: s_axi_rdata <= statWord;
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////

always_ff @(posedge clock) begin
    if (rst) begin
        cfg_reg <= CTRL_RST;
    end else if (!callActive) begin
        cfg_reg <= ctrl_reg;
    end
end

always_ff @(posedge clock) begin
    if (rst) begin
        callActive <= 1'b0;
        callAccept <= 1'b0;
        callReject <= 1'b0;
        callDrop <= 1'b0;
        sevenPar_reg <= 1'b0;
        oddPar_reg <= 1'b0;
    end else begin
        callAccept <= 1'b0;
        callReject <= 1'b0;
        callDrop <= dropCall;
        if (dropCall) begin
            callActive <= 1'b0;
        end else if (adopt) begin
            callActive <= 1'b1;
            callAccept <= callIn;
            sevenPar_reg <= callParams.sevenPar;
            oddPar_reg <= callParams.oddPar;
        end else if (callIn || (reloadIn && callActive)) begin
            callReject <= 1'b1;
        end
    end
end

always_ff @(posedge clock) begin
    if (rst) begin
        rateIdx_reg <= RATE_DEF;
    end else if (adopt) begin
        rateIdx_reg <= callParams.rate;
    end else if (!callActive && !autoSel) begin
        rateIdx_reg <= cfgRate;
    end else if (!callActive && abDone_reg) begin
        rateIdx_reg <= abIdx_reg;
    end
end

always_ff @(posedge clock) begin
    if (rst) begin
        abArmed_reg <= 1'b1;
        abMeas_reg <= 1'b0;
        abCnt_reg <= 20'h0;
        abDone_reg <= 1'b0;
        abIdx_reg <= RATE_DEF;
    end else begin
        abDone_reg <= 1'b0;
        if (callActive || !autoSel) begin
            abArmed_reg <= 1'b1;
            abMeas_reg <= 1'b0;
            abCnt_reg <= 20'h0;
        end else if (abArmed_reg) begin
            if (!rxLine) begin
                abMeas_reg <= 1'b1;
                if (abCnt_reg != 20'hfffff) begin
                    abCnt_reg <= abCnt_reg + 20'h1;
                end
            end else if (abMeas_reg) begin
                abMeas_reg <= 1'b0;
                abCnt_reg <= 20'h0;
                // Glitches shorter than three quarters of the fastest bit keep the detector armed
                if (pickRate(abCnt_reg) != RATE_NONE) begin
                    abArmed_reg <= 1'b0;
                    abDone_reg <= 1'b1;
                    abIdx_reg <= pickRate(abCnt_reg);
                end
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////

always_ff @(posedge clock) begin
    if (rst) begin
        rxSt_reg <= RX_IDLE;
        rxCnt_reg <= 20'h0;
        rxBit_reg <= 3'h0;
        rxShift_reg <= 8'h0;
        netTxValid <= 1'b0;
        netTxData <= 8'h0;
    end else begin
        netTxValid <= 1'b0;
        case (rxSt_reg)
            RX_IDLE: begin
                if (!rxLine && !rxHold) begin
                    rxSt_reg <= RX_START;
                    rxCnt_reg <= div >> 1;
                end
            end
            RX_START: begin
                if (rxCnt_reg != 20'h0) begin
                    rxCnt_reg <= rxCnt_reg - 20'h1;
                end else if (rxLine) begin
                    rxSt_reg <= RX_IDLE;
                end else begin
                    rxSt_reg <= RX_DATA;
                    rxCnt_reg <= div - 20'h1;
                    rxBit_reg <= 3'h0;
                end
            end
            RX_DATA: begin
                if (rxCnt_reg != 20'h0) begin
                    rxCnt_reg <= rxCnt_reg - 20'h1;
                end else begin
                    rxShift_reg <= {rxLine, rxShift_reg[7:1]};
                    rxCnt_reg <= div - 20'h1;
                    rxBit_reg <= rxBit_reg + 3'h1;
                    if (rxBit_reg == 3'h7) begin
                        rxSt_reg <= RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (rxCnt_reg != 20'h0) begin
                    rxCnt_reg <= rxCnt_reg - 20'h1;
                end else begin
                    // break chars forwarded; also up to release
                    netTxValid <= 1'b1;
                    netTxData <= rxShift_reg;
                    rxSt_reg <= RX_IDLE;
                end
            end
            default: rxSt_reg <= RX_IDLE;
        endcase
    end
end

always_ff @(posedge clock) begin
    if (rst) begin
        par_reg <= PAR_SPACE;
    end else if (cfgKbd && !callActive && netTxValid) begin
        if (netTxData[6:0] == 7'h0d) begin
            if (netTxData[7] ? (par_reg == PAR_SPACE || par_reg == PAR_ODD)
                    : (par_reg == PAR_EVEN || par_reg == PAR_MARK)) begin
                par_reg <= netTxData[7] ? PAR_EVEN : PAR_SPACE;
            end
        end else if (!(^netTxData[6:0])) begin
            // Even-weight chars split space from odd and even from mark
            if (netTxData[7] && par_reg == PAR_SPACE) begin
                par_reg <= PAR_ODD;
            end else if (netTxData[7] && par_reg == PAR_EVEN) begin
                par_reg <= PAR_MARK;
            end else if (!netTxData[7] && par_reg == PAR_ODD) begin
                par_reg <= PAR_SPACE;
            end else if (!netTxData[7] && par_reg == PAR_MARK) begin
                par_reg <= PAR_EVEN;
            end
        end
    end
end

always_ff @(posedge clock) begin
    if (rst) begin
        netRxReady <= 1'b1;
        txFrame_reg <= 11'h7ff;
        txLeft_reg <= 4'h0;
        txCnt_reg <= 20'h0;
        txLine_reg <= 1'b1;
    end else if (netRxReady) begin
        if (netRxValid) begin
            netRxReady <= 1'b0;
            txFrame_reg <= {2'h3, withParity(netRxData, txPar), 1'b0};
            txLeft_reg <= (rateIdx_reg == RATE_110) ? 4'hb : 4'ha;
            txCnt_reg <= div - 20'h1;
            txLine_reg <= 1'b0;
        end
    end else if (txCnt_reg != 20'h0) begin
        txCnt_reg <= txCnt_reg - 20'h1;
    end else if (txLeft_reg == 4'h1) begin
        netRxReady <= 1'b1;
        txLine_reg <= 1'b1;
    end else begin
        txFrame_reg <= {1'b1, txFrame_reg[10:1]};
        txLine_reg <= txFrame_reg[1];
        txLeft_reg <= txLeft_reg - 4'h1;
        txCnt_reg <= div - 20'h1;
    end
end

////////////////////////////////////////////////////////////////////////////////

always_ff @(posedge clock) begin
    if (rst || rxLine) begin
        brkCnt_reg <= '0;
    end else if (brkCnt_reg != TIMER_W'(BREAK_REL)) begin
        brkCnt_reg <= brkCnt_reg + TIMER_W'(1);
    end
end

always_ff @(posedge clock) begin
    if (rst) begin
        dtrCnt_reg <= '0;
    end else if (dropCall && !cfgDce) begin
        dtrCnt_reg <= TIMER_W'(DTR_DROP);
    end else if (dtrCnt_reg != '0) begin
        dtrCnt_reg <= dtrCnt_reg - TIMER_W'(1);
    end
end

// direction by mode; no RTS lead at all
always_ff @(posedge clock) begin
    if (rst) begin
        leadOut <= LEAD_IDLE;
        leadOe <= '0;
    end else begin
        leadOe <= cfgDce ? LEAD_DCE_OE : lead_t'(~LEAD_DCE_OE);
        leadOut.td <= txLine_reg;
        leadOut.rd <= txLine_reg;
        leadOut.cts <= 1'b1;
        leadOut.dsr <= 1'b1;
        leadOut.dcd <= callActive;
        leadOut.dtr <= dtrCnt_reg == '0;
        leadOut.ri <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////

always_ff @(posedge clock) begin
    if (rst) begin
        dg_reg <= DG_LAMP;
        dgCnt_reg <= '0;
        blink_reg <= 1'b0;
        indicator <= 6'h3f;
    end else begin
        case (dg_reg)
            DG_LAMP: begin
                indicator <= 6'h3f;
                dgCnt_reg <= dgCnt_reg + TIMER_W'(1);
                if (dgCnt_reg == TIMER_W'(LAMP - 1)) begin
                    dgCnt_reg <= '0;
                    dg_reg <= selfTestFail ? DG_FAIL : DG_PASS;
                end
            end
            DG_PASS: begin
                indicator <= 6'h00;
                if (btnRise) begin
                    dg_reg <= DG_MON;
                end
            end
            DG_FAIL: begin
                indicator <= blink_reg ? PAIR : 6'h00;
                dgCnt_reg <= dgCnt_reg + TIMER_W'(1);
                if (dgCnt_reg == TIMER_W'(BLINK_HALF - 1)) begin
                    dgCnt_reg <= '0;
                    blink_reg <= !blink_reg;
                end
                if (btnRise) begin
                    dg_reg <= DG_MON;
                end
            end
            DG_MON: begin
                indicator <= {leadS2_reg.td, leadS2_reg.rd, leadS2_reg.dtr,
                    leadS2_reg.dsr, leadS2_reg.cts, leadS2_reg.dcd};
            end
            default: dg_reg <= DG_LAMP;
        endcase
    end
end

endmodule

// ==== inc/port_adapter_pkg.sv ====
package port_adapter_pkg;

localparam int CLK_HZ = 20_000_000;
localparam int TOL_PERMIL = 1009;
localparam int BREAK_REL_MS = 1500;
localparam int BREAK_FWD_MS = 1200;
localparam int DTR_DROP_MS = 400;
localparam int LAMP_MS = 500;
localparam int BLINK_PER_S = 2;
localparam int BREAK_REL_CYC = BREAK_REL_MS * (CLK_HZ / 1000);
localparam int BREAK_FWD_CYC = BREAK_FWD_MS * (CLK_HZ / 1000);
localparam int DTR_DROP_CYC = DTR_DROP_MS * (CLK_HZ / 1000);
localparam int LAMP_CYC = LAMP_MS * (CLK_HZ / 1000);
localparam int BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_PER_S);
localparam int TIMER_W = 25;

localparam logic [3:0] NUM_RATES = 4'h9;
localparam logic [3:0] RATE_110 = 4'h0;
localparam logic [3:0] RATE_DEF = 4'h8;
localparam logic [3:0] RATE_NONE = 4'hf;

localparam logic [7:0] CTRL_OFS = 8'h00;
localparam logic [7:0] STAT_OFS = 8'h04;
localparam int CTRL_DCE = 0;
localparam int CTRL_KBD = 1;
localparam int CTRL_HANGUP = 2;
localparam int CTRL_RATE_LSB = 4;
localparam logic [7:0] CTRL_MASK = 8'hf3;
localparam logic [7:0] CTRL_RST = 8'hf2;
localparam int STAT_CALL = 0;
localparam int STAT_BRK = 1;
localparam int STAT_PAR_LSB = 2;
localparam int STAT_RATE_LSB = 5;
localparam int STAT_DIAG_LSB = 9;
localparam int STAT_AUTO = 11;
localparam logic [1:0] RESP_OKAY = 2'h0;
localparam logic [1:0] RESP_SLVERR = 2'h2;

typedef struct packed {
    logic td;
    logic rd;
    logic cts;
    logic dsr;
    logic dcd;
    logic dtr;
    logic ri;
} lead_t;

localparam lead_t LEAD_IDLE = 7'h60;
localparam lead_t LEAD_DCE_OE = 7'h3d;

typedef struct packed {
    logic sync;
    logic halfDup;
    logic eightPar;
    logic sevenPar;
    logic oddPar;
    logic [3:0] rate;
} call_par_t;

typedef enum logic [2:0] {
    PAR_SPACE = 3'h0, PAR_EVEN = 3'h1, PAR_MARK = 3'h2, PAR_ODD = 3'h3, PAR_NONE = 3'h6
} par_t;
typedef enum logic [1:0] {RX_IDLE = 2'h0, RX_START = 2'h1, RX_DATA = 2'h3, RX_STOP = 2'h2} rx_t;
typedef enum logic [1:0] {DG_LAMP = 2'h0, DG_PASS = 2'h1, DG_FAIL = 2'h3, DG_MON = 2'h2} diag_t;

function automatic logic [14:0] rateBps(input logic [3:0] idx);
    case (idx)
        4'h0: rateBps = 15'h006e;
        4'h1: rateBps = 15'h0096;
        4'h2: rateBps = 15'h012c;
        4'h3: rateBps = 15'h0258;
        4'h4: rateBps = 15'h04b0;
        4'h5: rateBps = 15'h0960;
        4'h6: rateBps = 15'h12c0;
        4'h7: rateBps = 15'h2580;
        default: rateBps = 15'h4b00;
    endcase
endfunction

// Cycles per bit, with the fast tolerance folded in
function automatic logic [19:0] bitDiv(input logic [3:0] idx);
    bitDiv = 20'(longint'(CLK_HZ) * 64'h3e8 / (longint'(rateBps(idx)) * TOL_PERMIL));
endfunction

function automatic logic [7:0] withParity(input logic [7:0] d, input par_t p);
    case (p)
        PAR_SPACE: withParity = {1'b0, d[6:0]};
        PAR_EVEN: withParity = {^d[6:0], d[6:0]};
        PAR_ODD: withParity = {~^d[6:0], d[6:0]};
        PAR_MARK: withParity = {1'b1, d[6:0]};
        default: withParity = d;
    endcase
endfunction

endpackage

// ==== tb/port_adapter_checker.sv ====
`timescale 1ns/100ps
module port_adapter_checker
    import port_adapter_pkg::*;
(
    input wire logic clock, // Clock
    input wire logic rst, // Reset
    input wire logic s_axi_awvalid, // Aw valid
    input wire logic s_axi_wvalid, // W valid
    input wire logic s_axi_awready, // Aw ready
    input wire logic s_axi_wready, // W ready
    input wire logic s_axi_bvalid, // B valid
    input wire logic s_axi_bready, // B ready
    input wire logic s_axi_arvalid, // Ar valid
    input wire logic s_axi_rvalid, // R valid
    input wire lead_t leadOut, // Lead levels
    input wire lead_t leadOe, // Lead enables
    input wire logic callIn, // Call pulse
    input wire call_par_t callParams, // Call parameters
    input wire logic callAccept, // Taken
    input wire logic callReject, // Refused
    input wire logic callDrop, // Released
    input wire logic callActive, // Call up
    input wire logic [5:0] indicator // Lamps
);
    logic okCall;
    assign okCall = !callParams.sync && !callParams.halfDup && !callParams.eightPar
        && callParams.rate < 4'h9;
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    AST_WR: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
        |=> s_axi_awready && s_axi_wready && s_axi_bvalid) else $error("write not answered");
    AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    AST_RD: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
        else $error("read not answered");
    AST_REJ: assert property (callIn && !okCall |=> callReject && !callAccept)
        else $error("bad call not refused");
    AST_ACC: assert property (callIn && okCall && !callActive |=> callAccept && callActive)
        else $error("good call not taken");
    AST_IND: assert property ($fell(rst) |-> indicator == 6'h3f)
        else $error("lamps not lit after reset");
    AST_OE: assert property (!$past(rst) |-> leadOe == LEAD_DCE_OE || leadOe == 7'h42)
        else $error("lead directions wrong");
    AST_DTR: assert property (callDrop && leadOe.dtr |-> ##[1:4] !leadOut.dtr)
        else $error("ready lead not dropped");
endmodule
bind async_rs232_port_adapter port_adapter_checker chk_u (.*);

// ==== tb/rs232_equipment.sv ====
`timescale 1ns/100ps
module rs232_equipment
    import port_adapter_pkg::*;
#(parameter int BIT = 1032) (
    input wire logic clock, // Bench clock
    input wire lead_t leadOut, // Adapter levels
    input wire lead_t leadOe, // Adapter enables
    output lead_t leadIn // Resolved pins
);
    logic line = 1'b1;
    lead_t own;
    // Equipment holds CTS, DSR and DCD on, DTR and RI off; data idles at mark
    assign own = {1'b1, line, 3'b111, 2'b00};
    assign leadIn = (leadOut & leadOe) | (own & ~leadOe);
    task automatic sendChar(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line <= f[i];
            repeat (BIT) @(posedge clock);
        end
    endtask
    task automatic space(input int n);
        line <= 1'b0;
        repeat (n) @(posedge clock);
        line <= 1'b1;
    endtask
    // Counts start bit, then samples mid-bit
    task automatic getChar(output int n, output logic [7:0] d);
        n = 0;
        while (leadIn.td) @(posedge clock);
        while (!leadIn.td) begin
            n++;
            @(posedge clock);
        end
        repeat (BIT / 2) @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            d[i] = leadIn.td;
            repeat (BIT) @(posedge clock);
        end
    endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
module tb_top import port_adapter_pkg::*;;
    logic clock, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr, netRxData, netTxData, d;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic netRxValid, netRxReady, netTxValid, callIn, reloadIn, callAccept, callReject;
    logic callDrop, callActive, selfTestFail, selButton;
    logic [5:0] indicator;
    lead_t leadIn, leadOut, leadOe;
    call_par_t callParams;
    call_par_t bad [4] = '{9'h108, 9'h088, 9'h048, 9'h009};
    int n_mismatch = 0, tests_run = 0, cyc = 0, n;
    async_rs232_port_adapter #(.BREAK_REL(15000), .BREAK_FWD(12000), .DTR_DROP(50),
        .LAMP(20), .BLINK_HALF(10)) dut_u (.*);
    rs232_equipment eq_u (.clock, .leadOut, .leadOe, .leadIn);
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge clock); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        while (!s_axi_bvalid) @(posedge clock);
        chk(s_axi_bresp, (a == CTRL_OFS || a == STAT_OFS) ? RESP_OKAY : RESP_SLVERR);
        s_axi_bready <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clock); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge clock);
        s_axi_rready <= 1'b0;
        chk({s_axi_rresp, s_axi_rdata}, e);
        @(posedge clock);
    endtask
    task automatic call(input logic r, input call_par_t p, input logic [1:0] e);
        callParams <= p;
        callIn <= !r;
        reloadIn <= r;
        @(posedge clock);
        callIn <= 1'b0;
        reloadIn <= 1'b0;
        @(posedge clock);
        chk({callAccept, callReject}, e);
    endtask
    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Whole run needs about 50k cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_mismatch++;
            stop_test;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, netRxData, netRxValid} = '0;
        {callIn, reloadIn, callParams, selfTestFail, selButton} = '0;
        s_axi_wstrb = 4'hf;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        chk(indicator, 6'h3f);
        rd(8'h00, {RESP_OKAY, 32'hf2});
        rd(8'h10, {RESP_SLVERR, 32'h0});
        s_axi_wstrb <= 4'he;
        wr(8'h00, 32'h80);
        s_axi_wstrb <= 4'hf;
        rd(8'h00, {RESP_OKAY, 32'hf2});
        repeat (30) @(posedge clock);
        chk(indicator, 6'h00);
        $display("reset test done");
        wr(8'h00, 32'h80);
        rd(8'h00, {RESP_OKAY, 32'h80});
        for (int i = 0; i < 4; i++) call(1'b0, bad[i], 2'b01);
        call(1'b0, 9'h038, 2'b10);
        wr(8'h00, 32'h81);
        chk(leadOe, 7'h42);
        $display("call test done");
        netRxData <= 8'ha5;
        netRxValid <= 1'b1;
        do @(posedge clock); while (!netRxReady);
        netRxValid <= 1'b0;
        eq_u.getChar(n, d);
        chk(n, 1032);
        chk(d, 8'h25);
        repeat (1032) @(posedge clock);
        fork
            eq_u.sendChar(8'hc3);
            begin
                while (!netTxValid) @(posedge clock);
                chk(netTxData, 8'hc3);
            end
        join
        call(1'b1, 9'h128, 2'b01);
        call(1'b1, 9'h027, 2'b00);
        rd(8'h04, {RESP_OKAY, 32'h2e1});
        $display("data test done");
        eq_u.space(11000);
        repeat (2064) @(posedge clock);
        chk(callActive, 1'b1);
        eq_u.space(16000);
        chk(callActive, 1'b0);
        $display("break test done");
        rst <= 1'b1;
        selfTestFail <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        repeat (35) @(posedge clock);
        chk(indicator, 6'h30);
        repeat (10) @(posedge clock);
        chk(indicator, 6'h00);
        selButton <= 1'b1;
        repeat (5) @(posedge clock);
        selButton <= 1'b0;
        chk(indicator, 6'h3f);
        rd(8'h04, {RESP_OKAY, 32'hd00});
        $display("diag test done");
        stop_test;
    end
endmodule
